// File: rtl/ifc_top.sv
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
module ifc_top #(
    parameter int NUM_SRC = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ifc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [ifc_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [ifc_pkg::DAT_W-1:0] wb_dat_i,
    output logic [ifc_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NUM_SRC-1:0] source_i,
    output logic standard_request_out_n_o,
    output logic fast_request_out_n_o,
    output logic protection_enable_o
);
    // ======================================================
    // elaboration checks
    if (NUM_SRC < 2 || NUM_SRC > ifc_pkg::DAT_W) begin : g_bad_num_src
        $error("NUM_SRC must lie between 2 and the bus width");
    end

    // ======================================================
    // helpers
    function automatic ifc_pkg::ifc_reg_t decode(
        input logic [ifc_pkg::ADR_W-1:0] adr
    );
        logic [ifc_pkg::ADR_W-1:ifc_pkg::WORD_LSB] w;
        w = adr[ifc_pkg::ADR_W-1:ifc_pkg::WORD_LSB];
        if (w == ifc_pkg::OFS_DEBUG_CONTROL[ifc_pkg::ADR_W-1:ifc_pkg::WORD_LSB]) begin
            return ifc_pkg::IFC_R_DCR;
        end else if (w == ifc_pkg::OFS_FF_ENABLE[ifc_pkg::ADR_W-1:ifc_pkg::WORD_LSB]) begin
            return ifc_pkg::IFC_R_FFER;
        end else if (w == ifc_pkg::OFS_FF_DISABLE[ifc_pkg::ADR_W-1:ifc_pkg::WORD_LSB]) begin
            return ifc_pkg::IFC_R_FFDR;
        end else if (w == ifc_pkg::OFS_FF_STATUS[ifc_pkg::ADR_W-1:ifc_pkg::WORD_LSB]) begin
            return ifc_pkg::IFC_R_FFSR;
        end else if (w == ifc_pkg::OFS_PENDING[ifc_pkg::ADR_W-1:ifc_pkg::WORD_LSB]) begin
            return ifc_pkg::IFC_R_PEND;
        end else if (w == ifc_pkg::OFS_PENDING_CLEAR[ifc_pkg::ADR_W-1:ifc_pkg::WORD_LSB]) begin
            return ifc_pkg::IFC_R_PCLR;
        end
        return ifc_pkg::IFC_R_NONE;
    endfunction

    // only lanes with sel high contribute their ones
    function automatic logic [NUM_SRC-1:0] lane_ones(
        input logic [ifc_pkg::DAT_W-1:0] dat,
        input logic [ifc_pkg::SEL_W-1:0] sel
    );
        logic [ifc_pkg::DAT_W-1:0] m;
        m = '0;
        for (int i = 0; i < ifc_pkg::SEL_W; i++) begin
            if (sel[i]) begin
                m[i*ifc_pkg::LANE_W +: ifc_pkg::LANE_W] =
                    dat[i*ifc_pkg::LANE_W +: ifc_pkg::LANE_W];
            end
        end
        return m[NUM_SRC-1:0];
    endfunction

    // ======================================================
    // bus slave
    logic load;
    logic write;
    ifc_pkg::ifc_reg_t sel_reg;
    logic [NUM_SRC-1:0] wr_ones;

    ifc_wb_slave u_slave (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(wb_cyc_i),
        .stb_i(wb_stb_i),
        .we_i(wb_we_i),
        .ack_o(wb_ack_o),
        .load_o(load),
        .write_o(write)
    );

    assign sel_reg = decode(wb_adr_i);
    assign wr_ones = lane_ones(wb_dat_i, wb_sel_i);

    // ======================================================
    // debug control
    logic protect_q;
    logic protect_d;
    logic gmask_q;
    logic gmask_d;

    always_comb begin
        protect_d = protect_q;
        gmask_d = gmask_q;
        // both bits sit in lane 0; a write without that lane leaves them
        if (write && sel_reg == ifc_pkg::IFC_R_DCR && wb_sel_i[0]) begin
            protect_d = wb_dat_i[ifc_pkg::PROTECT_BIT];
            gmask_d = wb_dat_i[ifc_pkg::GMASK_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            protect_q <= ifc_pkg::RST_PROTECT;
            gmask_q <= ifc_pkg::RST_GMASK;
        end else begin
            protect_q <= protect_d;
            gmask_q <= gmask_d;
        end
    end

    // protection is only stored and exported; nothing here reacts to it
    assign protection_enable_o = protect_q;

    // ======================================================
    // fast forcing state
    logic [NUM_SRC-1:0] ff_q;
    logic [NUM_SRC-1:0] ff_d;
    logic [NUM_SRC-1:0] clear_mask;

    always_comb begin
        ff_d = ff_q;
        if (write && sel_reg == ifc_pkg::IFC_R_FFER) begin
            ff_d = ff_q | wr_ones;
        end
        if (write && sel_reg == ifc_pkg::IFC_R_FFDR) begin
            ff_d = ff_q & ~wr_ones;
        end
        // fast source bit has no flop
        ff_d[ifc_pkg::FAST_SRC_BIT] = 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ff_q <= '0;
        end else begin
            ff_q <= ff_d;
        end
    end

    always_comb begin
        clear_mask = '0;
        if (write && sel_reg == ifc_pkg::IFC_R_PCLR) begin
            clear_mask = wr_ones;
        end
    end

    // ======================================================
    // pending and request lines
    logic [NUM_SRC-1:0] pending;

    ifc_route #(
        .NUM_SRC(NUM_SRC)
    ) u_route (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .source_i(source_i),
        .clear_i(clear_mask),
        .forced_i(ff_q),
        .gmask_i(gmask_q),
        .pending_o(pending),
        .standard_n_o(standard_request_out_n_o),
        .fast_n_o(fast_request_out_n_o)
    );

    // ======================================================
    // read data
    logic [ifc_pkg::DAT_W-1:0] rdat_q;
    logic [ifc_pkg::DAT_W-1:0] rdat_d;

    always_comb begin
        rdat_d = rdat_q;
        if (load) begin
            rdat_d = ifc_pkg::RD_ZERO;
            case (sel_reg)
                ifc_pkg::IFC_R_DCR: begin
                    rdat_d[ifc_pkg::PROTECT_BIT] = protect_q;
                    rdat_d[ifc_pkg::GMASK_BIT] = gmask_q;
                end
                ifc_pkg::IFC_R_FFSR: begin
                    rdat_d[NUM_SRC-1:0] = ff_q;
                end
                ifc_pkg::IFC_R_PEND: begin
                    rdat_d[NUM_SRC-1:0] = pending;
                end
                // write-only and unmapped words read as zero
                default: begin
                    rdat_d = ifc_pkg::RD_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= ifc_pkg::RD_ZERO;
        end else begin
            rdat_q <= rdat_d;
        end
    end

    assign wb_dat_o = rdat_q;

    // ======================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // pending sources that are not forced; all but FAST_SRC_BIT belong on the standard line
    logic [NUM_SRC-1:0] std_routed;
    assign std_routed = pending & ~ff_q;

    sequence s_dcr_write;
        write && sel_reg == ifc_pkg::IFC_R_DCR && wb_sel_i[0];
    endsequence

    sequence s_ffer_write;
        write && sel_reg == ifc_pkg::IFC_R_FFER && wb_sel_i[0];
    endsequence

    sequence s_ffdr_write;
        write && sel_reg == ifc_pkg::IFC_R_FFDR && wb_sel_i[0];
    endsequence

    AST_PROTECT_TRACKS: assert property (
        s_dcr_write |=> protection_enable_o == $past(wb_dat_i[ifc_pkg::PROTECT_BIT])
    ) else $error("protection bit did not take written value");

    AST_PROTECT_HOLDS: assert property (
        !(write && sel_reg == ifc_pkg::IFC_R_DCR && wb_sel_i[0]) |=> $stable(protection_enable_o)
    ) else $error("protection bit changed without a write");

    AST_DCR_READBACK: assert property (
        load && sel_reg == ifc_pkg::IFC_R_DCR |=>
        wb_dat_o[ifc_pkg::PROTECT_BIT] == $past(protect_q) &&
        wb_dat_o[ifc_pkg::GMASK_BIT] == $past(gmask_q)
    ) else $error("debug control read did not return stored bits");

    AST_GMASK_HOLDS: assert property (
        gmask_q ##1 gmask_q |-> standard_request_out_n_o && fast_request_out_n_o
    ) else $error("request line active while global mask set");

    AST_FF_SET: assert property (
        s_ffer_write ##0 wb_dat_i[1] |=> ff_q[1]
    ) else $error("fast forcing enable write did not set bit");

    AST_FF_ZERO_KEEPS: assert property (
        write && sel_reg == ifc_pkg::IFC_R_FFER && wr_ones == '0 |=> $stable(ff_q)
    ) else $error("zero write to enable register changed state");

    AST_FF_CLEAR: assert property (
        s_ffdr_write ##0 wb_dat_i[1] |=> !ff_q[1]
    ) else $error("fast forcing disable write did not clear bit");

    AST_FF_STATUS: assert property (
        load && sel_reg == ifc_pkg::IFC_R_FFSR |=> wb_ack_o ##0
        wb_dat_o[NUM_SRC-1:0] == $past(ff_q)
    ) else $error("status read did not return forcing state");

    AST_FAST_BIT_IDLE: assert property (
        ##1 !ff_q[ifc_pkg::FAST_SRC_BIT]
    ) else $error("fast source bit carries forcing");

    AST_FF_ONLY_BY_CMD: assert property (
        !(write && (sel_reg == ifc_pkg::IFC_R_FFER || sel_reg == ifc_pkg::IFC_R_FFDR))
        |=> $stable(ff_q)
    ) else $error("forcing state changed without a command write");

    AST_WO_READS_ZERO: assert property (
        load && (sel_reg == ifc_pkg::IFC_R_FFER || sel_reg == ifc_pkg::IFC_R_FFDR ||
        sel_reg == ifc_pkg::IFC_R_PCLR) |=> wb_dat_o == ifc_pkg::RD_ZERO
    ) else $error("write-only register read as nonzero");

    AST_UNMAPPED_READS_ZERO: assert property (
        load && sel_reg == ifc_pkg::IFC_R_NONE |=> wb_dat_o == ifc_pkg::RD_ZERO
    ) else $error("unmapped word read as nonzero");

    AST_FORCED_TO_FAST: assert property (
        !gmask_q && |(pending & ff_q) |=> !fast_request_out_n_o
    ) else $error("forced pending source did not raise fast line");

    // idle and all-forced cases both keep the standard line quiet
    AST_FORCED_NOT_STD: assert property (
        std_routed[NUM_SRC-1:ifc_pkg::FAST_SRC_BIT+1] == '0
        |=> standard_request_out_n_o
    ) else $error("forced source leaked onto standard line");

    AST_STD_ROUTED: assert property (
        !gmask_q && |std_routed[NUM_SRC-1:ifc_pkg::FAST_SRC_BIT+1]
        |=> !standard_request_out_n_o
    ) else $error("unforced pending source did not raise standard line");

    AST_FAST_SOURCE_ROUTED: assert property (
        !gmask_q && pending[ifc_pkg::FAST_SRC_BIT] |=> !fast_request_out_n_o
    ) else $error("fast source did not raise fast line");

    AST_ACK_ONE_CYCLE: assert property (
        wb_ack_o |=> !wb_ack_o
    ) else $error("ack held longer than one cycle");

    // an ack with no request behind it would let a stray write land
    AST_ACK_NEEDS_REQ: assert property (
        wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i)
    ) else $error("ack without a preceding request");
endmodule

// File: rtl/ifc_pkg.sv
package ifc_pkg;
    // ======================================================
    // bus geometry
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int LANE_W = 8;
    localparam int WORD_LSB = 2;

    // ======================================================
    // register byte offsets
    localparam logic [ADR_W-1:0] OFS_DEBUG_CONTROL = 8'h00;
    localparam logic [ADR_W-1:0] OFS_FF_ENABLE = 8'h04;
    localparam logic [ADR_W-1:0] OFS_FF_DISABLE = 8'h08;
    localparam logic [ADR_W-1:0] OFS_FF_STATUS = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_PENDING = 8'h10;
    localparam logic [ADR_W-1:0] OFS_PENDING_CLEAR = 8'h14;

    // ======================================================
    // field positions and reset values
    localparam int PROTECT_BIT = 0;
    localparam int GMASK_BIT = 1;
    localparam int FAST_SRC_BIT = 0;
    localparam logic RST_PROTECT = 1'b0;
    localparam logic RST_GMASK = 1'b0;
    localparam logic [DAT_W-1:0] RD_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        IFC_R_DCR,
        IFC_R_FFER,
        IFC_R_FFDR,
        IFC_R_FFSR,
        IFC_R_PEND,
        IFC_R_PCLR,
        IFC_R_NONE
    } ifc_reg_t;
endpackage

// File: rtl/ifc_wb_slave.sv
`timescale 1ns/100ps
module ifc_wb_slave (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    output logic ack_o,
    output logic load_o,
    output logic write_o
);
    logic ack_q;
    logic ack_d;

    // ======================================================
    // one wait state, ack for exactly one cycle
    always_comb begin
        ack_d = cyc_i & stb_i & ~ack_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    assign ack_o = ack_q;
    // read data is captured together with the ack edge
    assign load_o = ack_d;
    // writes land on the edge where the master sees ack
    assign write_o = cyc_i & stb_i & we_i & ack_q;
endmodule

// File: rtl/ifc_route.sv
`timescale 1ns/100ps
module ifc_route #(
    parameter int NUM_SRC = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [NUM_SRC-1:0] source_i,
    input wire logic [NUM_SRC-1:0] clear_i,
    input wire logic [NUM_SRC-1:0] forced_i,
    input wire logic gmask_i,
    output logic [NUM_SRC-1:0] pending_o,
    output logic standard_n_o,
    output logic fast_n_o
);
    logic [NUM_SRC-1:0] pend_q;
    logic [NUM_SRC-1:0] pend_d;
    logic std_n_q;
    logic std_n_d;
    logic fast_n_q;
    logic fast_n_d;
    logic [NUM_SRC-1:0] fast_sel;

    // ======================================================
    // pending capture and output steering
    always_comb begin
        // a new source level beats a clear in the same cycle
        pend_d = (pend_q & ~clear_i) | source_i;
        fast_sel = forced_i;
        fast_sel[ifc_pkg::FAST_SRC_BIT] = 1'b1;
        std_n_d = ~|(pend_q & ~fast_sel);
        fast_n_d = ~|(pend_q & fast_sel);
        if (gmask_i) begin
            std_n_d = 1'b1;
            fast_n_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q <= '0;
            std_n_q <= 1'b1;
            fast_n_q <= 1'b1;
        end else begin
            pend_q <= pend_d;
            std_n_q <= std_n_d;
            fast_n_q <= fast_n_d;
        end
    end

    assign pending_o = pend_q;
    assign standard_n_o = std_n_q;
    assign fast_n_o = fast_n_q;
endmodule

// File: test/ifc_core_model.sv
`timescale 1ns/100ps
// ==========================================
// processor core side: samples both request lines
module ifc_core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic standard_n_i,
    input wire logic fast_n_i,
    output logic std_seen_o,
    output logic fast_seen_o
);
    // lines are active low; a core only reacts to sampled levels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            std_seen_o <= 1'b0;
            fast_seen_o <= 1'b0;
        end else begin
            std_seen_o <= ~standard_n_i;
            fast_seen_o <= ~fast_n_i;
        end
    end
endmodule

// File: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic [31:0] src = 32'h0;
    logic std_n, fast_n, protect, std_seen, fast_seen;
    int err_count = 0;
    int checks = 0;

    always #10 clk_i = ~clk_i;

    ifc_top ifc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .source_i(src), .standard_request_out_n_o(std_n),
        .fast_request_out_n_o(fast_n), .protection_enable_o(protect));

    ifc_core_model ifc_core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .standard_n_i(std_n),
        .fast_n_i(fast_n), .std_seen_o(std_seen), .fast_seen_o(fast_seen));

    // ==========================================
    // comparison and closing
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================
    // classic single wishbone cycle, waits for ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        // ack is sampled at each rising edge; only the watchdog ends a hang
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            @(posedge clk_i);
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, 4'hF, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, 4'hF, r);
        chk(r, exp);
    endtask

    // lines are looked at once the routing has settled
    task automatic lines(input logic s, input logic f);
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk({30'h0, std_seen, fast_seen}, {30'h0, s, f});
    endtask

    initial begin
        #200us;
        err_count++;
        give_verdict();
    end

    initial begin
        logic [31:0] r;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(ifc_pkg::OFS_DEBUG_CONTROL, 32'h0);
        rd(ifc_pkg::OFS_FF_STATUS, 32'h0);
        rd(8'h1C, 32'h0);
        wr(ifc_pkg::OFS_DEBUG_CONTROL, 32'h1);
        rd(ifc_pkg::OFS_DEBUG_CONTROL, 32'h1);
        chk({31'h0, protect}, 32'h1);
        bus(1'b1, ifc_pkg::OFS_DEBUG_CONTROL, 32'h0, 4'h2, r);
        chk({31'h0, protect}, 32'h1);
        wr(ifc_pkg::OFS_DEBUG_CONTROL, 32'h0);
        chk({31'h0, protect}, 32'h0);
        $display("test debug_control done");

        wr(ifc_pkg::OFS_FF_ENABLE, 32'hFFFF_FFFF);
        rd(ifc_pkg::OFS_FF_STATUS, 32'hFFFF_FFFE);
        wr(ifc_pkg::OFS_FF_DISABLE, 32'h8000_000B);
        rd(ifc_pkg::OFS_FF_STATUS, 32'h7FFF_FFF4);
        wr(ifc_pkg::OFS_FF_ENABLE, 32'h0000_0000);
        rd(ifc_pkg::OFS_FF_STATUS, 32'h7FFF_FFF4);
        wr(ifc_pkg::OFS_FF_ENABLE, 32'h8000_0001);
        rd(ifc_pkg::OFS_FF_STATUS, 32'hFFFF_FFF4);
        rd(ifc_pkg::OFS_FF_ENABLE, 32'h0);
        wr(ifc_pkg::OFS_FF_STATUS, 32'h0);
        rd(ifc_pkg::OFS_FF_STATUS, 32'hFFFF_FFF4);
        $display("test fast_forcing_regs done");

        wr(ifc_pkg::OFS_FF_DISABLE, 32'hFFFF_FFFF);
        @(posedge clk_i);
        src <= 32'h0000_0008;
        lines(1'b1, 1'b0);
        rd(ifc_pkg::OFS_PENDING, 32'h8);
        wr(ifc_pkg::OFS_DEBUG_CONTROL, 32'h2);
        rd(ifc_pkg::OFS_DEBUG_CONTROL, 32'h2);
        lines(1'b0, 1'b0);
        wr(ifc_pkg::OFS_DEBUG_CONTROL, 32'h0);
        lines(1'b1, 1'b0);
        wr(ifc_pkg::OFS_FF_ENABLE, 32'h8);
        lines(1'b0, 1'b1);
        wr(ifc_pkg::OFS_DEBUG_CONTROL, 32'h2);
        lines(1'b0, 1'b0);
        wr(ifc_pkg::OFS_DEBUG_CONTROL, 32'h0);
        lines(1'b0, 1'b1);
        @(posedge clk_i);
        src <= 32'h0;
        wr(ifc_pkg::OFS_PENDING_CLEAR, 32'h8);
        lines(1'b0, 1'b0);
        rd(ifc_pkg::OFS_PENDING, 32'h0);
        @(posedge clk_i);
        src <= 32'h0000_0001;
        lines(1'b0, 1'b1);
        @(posedge clk_i);
        src <= 32'h0;
        wr(ifc_pkg::OFS_PENDING_CLEAR, 32'h1);
        lines(1'b0, 1'b0);
        $display("test routing done");
        give_verdict();
    end
endmodule
